// ===== dv/adc_conv_ctrl_tb.sv
// Testbench of the converter control block with front-end model
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl_tb
  import adc_ctrl_pkg::*;
;
  logic            mclk = 1'b0;
  logic            srst = 1'b1;
  logic [7:0]      addr = 8'h00;
  logic [7:0]      wdata = 8'h00;
  logic            wr_stb = 1'b0;
  logic            rd_stb = 1'b0;
  logic            power_down = 1'b0;
  logic            conv_irq_en = 1'b0;
  logic [7:0]      rdata;
  logic            conv_irq_req;
  logic            irq;
  logic            cmp_pin;
  logic [2:0]      input_select;
  logic [7:0]      channel_connect;
  logic            analog_power;
  logic            sample_hold;
  logic [9:0]      dac_code;
  logic [7:0][9:0] levels = {10'h3fe, 10'h001, 10'h1ff, 10'h200,
                             10'h2aa, 10'h155, 10'h000, 10'h3ff};
  int              bad_count = 0;
  int              compares = 0;
  int              tad_tab[8] = '{2, 4, 6, 8, 12, 16, 24, 32};
  // ====================
  // Design and front end
  always #2.5 mclk = ~mclk;
  adc_conv_ctrl i_adc_conv_ctrl (
    .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .power_down(power_down), .conv_irq_en(conv_irq_en),
    .conv_irq_req(conv_irq_req), .irq(irq), .cmp_pin(cmp_pin),
    .input_select(input_select), .channel_connect(channel_connect),
    .analog_power(analog_power), .sample_hold(sample_hold), .dac_code(dac_code));
  afe_model i_afe_model (
    .mclk(mclk), .analog_power(analog_power), .channel_connect(channel_connect),
    .dac_code(dac_code), .levels(levels), .cmp_pin(cmp_pin));
  // ====================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Drives right after an edge; a quiet cycle separates two calls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic res(output logic [9:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(RES_HI_ADDR, h);
    rd(RES_LO_ADDR, l);
    v = {h, l[1:0]};
  endtask : res
  // Polls completion; each read takes two cycles, n counts cycles spent
  task automatic wait_done(input int lim, output int n);
    logic [7:0] s;
    n = 0;
    s = 8'h00;
    while (s[STAT_DONE_BIT] !== 1'b1 && n < lim) begin
      rd(IRQ_STAT_ADDR, s);
      n += 2;
    end
  endtask : wait_done
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle
  // ====================
  // Scenarios
  task automatic s_reset();
    logic [7:0] d;
    rd(CTRL_ADDR, d);
    chk(16'(d), 16'h0000);
    rd(TIME_ADDR, d);
    chk(16'(d), 16'h0000);
    chk(16'({irq, analog_power, channel_connect}), 16'h0000);
  endtask : s_reset
  task automatic s_convert();
    logic [7:0] d;
    logic [9:0] v;
    int         n;
    wr(TIME_ADDR, 8'h60);
    for (int ch = 0; ch < 8; ch++) begin
      wr(CTRL_ADDR, {4'h8, ch[2:0], 1'b1});
      wait_done(300, n);
      chk(16'(input_select), 16'(ch));
      res(v);
      chk(16'(v), 16'(levels[ch]));
      rd(CTRL_ADDR, d);
      chk(16'(d), 16'({4'hc, ch[2:0], 1'b0}));
      wr(IRQ_CLR_ADDR, 8'h03);
      wr(CTRL_ADDR, 8'h80);
    end
  endtask : s_convert
  task automatic s_irq();
    logic [7:0] d;
    int         n;
    wr(IRQ_EN_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h81);
    wait_done(300, n);
    wr(IRQ_STAT_ADDR, 8'h00);
    chk(16'(irq), 16'h0000);
    wr(IRQ_EN_ADDR, 8'h01);
    chk(16'({irq, conv_irq_req}), 16'h0002);
    @(posedge mclk);
    conv_irq_en <= 1'b1;
    idle(20);
    rd(IRQ_STAT_ADDR, d);
    chk(16'({d, irq, conv_irq_req}), 16'h0007);
    wr(CTRL_ADDR, 8'h80);
    chk(16'({irq, conv_irq_req}), 16'h0002);
    wr(IRQ_CLR_ADDR, 8'h01);
    chk(16'(irq), 16'h0000);
    rd(IRQ_CLR_ADDR, d);
    chk(16'(d), 16'h0000);
    rd(8'h10, d);
    chk(16'(d), 16'h0000);
  endtask : s_irq
  task automatic s_abort();
    logic [7:0] d;
    logic [9:0] v;
    wr(CTRL_ADDR, 8'h83);
    idle(30);
    wr(CTRL_ADDR, 8'h82);
    idle(150);
    rd(IRQ_STAT_ADDR, d);
    res(v);
    chk(16'({d, sample_hold}), 16'h0000);
    chk(16'(v), 16'(levels[0]));
  endtask : s_abort
  task automatic s_off();
    logic [7:0] d;
    wr(CTRL_ADDR, 8'h21);
    rd(CTRL_ADDR, d);
    chk(16'(d), 16'h0020);
    idle(150);
    rd(IRQ_STAT_ADDR, d);
    chk(16'({d, analog_power, sample_hold}), 16'h0000);
    wr(CTRL_ADDR, 8'h80);
    idle(1);
    chk(16'(analog_power), 16'h0001);
  endtask : s_off
  task automatic s_compare();
    logic [7:0] d;
    wr(CMPV_HI_ADDR, 8'h40);
    wr(CMPV_LO_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'had);
    idle(400);
    rd(CTRL_ADDR, d);
    chk(16'(d), 16'h00ad);
    rd(IRQ_STAT_ADDR, d);
    chk(16'(d), 16'h0001);
    wr(CTRL_ADDR, 8'ha5);
    idle(300);
    rd(CTRL_ADDR, d);
    chk(16'(d), 16'h00e5);
    rd(IRQ_STAT_ADDR, d);
    chk(16'(d), 16'h0003);
    wr(CTRL_ADDR, 8'ha4);
    wr(IRQ_CLR_ADDR, 8'h03);
    idle(300);
    rd(IRQ_STAT_ADDR, d);
    chk(16'(d), 16'h0000);
  endtask : s_compare
  task automatic s_pd();
    logic [7:0] d;
    logic [9:0] v;
    int         n;
    wr(CTRL_ADDR, 8'h85);
    idle(40);
    @(posedge mclk);
    power_down <= 1'b1;
    idle(200);
    rd(IRQ_STAT_ADDR, d);
    chk(16'({d, analog_power, sample_hold}), 16'h0000);
    @(posedge mclk);
    power_down <= 1'b0;
    wait_done(300, n);
    res(v);
    chk(16'(v), 16'(levels[2]));
    wr(IRQ_CLR_ADDR, 8'h03);
  endtask : s_pd
  // Every divider code at the lower sample clamp, then the upper clamp and a mid value
  task automatic s_timing();
    logic [2:0] code[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 7, 1};
    logic [3:0] samp[10] = '{0, 0, 0, 0, 0, 0, 0, 0, 4'hf, 4'h7};
    int         smp[10] = '{2, 2, 2, 2, 2, 2, 2, 2, 15, 8};
    int         n;
    int         e;
    for (int k = 0; k < 10; k++) begin
      wr(TIME_ADDR, {code[k], 1'b0, samp[k]});
      wr(CTRL_ADDR, 8'h81);
      wait_done(1000, n);
      e = (smp[k] + 12) * tad_tab[code[k]];
      chk(16'(n >= e && n <= e + 4), 16'h0001);
      wr(IRQ_CLR_ADDR, 8'h03);
      wr(CTRL_ADDR, 8'h80);
    end
  endtask : s_timing
  // ====================
  // Run control
  task automatic wrap_up();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  // Watchdog sized at about four and a half times the expected run
  initial begin
    repeat (25000) @(posedge mclk);
    bad_count++;
    wrap_up();
  end
  // Reset for four cycles, two quiet edges, then the scenarios
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    idle(2);
    s_reset();
    s_convert();
    s_irq();
    s_abort();
    s_off();
    s_compare();
    s_pd();
    s_timing();
    wrap_up();
  end
endmodule : adc_conv_ctrl_tb
`default_nettype wire

// ===== dv/adc_conv_monitor.sv
// Checker of the converter control port relations
`timescale 1ns/1ps
`default_nettype none
module adc_conv_monitor
  import adc_ctrl_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic [7:0] addr,
  input wire logic       wr_stb,
  input wire logic       power_down,
  input wire logic       conv_irq_en,
  input wire logic       conv_irq_req,
  input wire logic       irq,
  input wire logic [2:0] input_select,
  input wire logic [7:0] channel_connect,
  input wire logic       analog_power,
  input wire logic       sample_hold
);
  // ====================
  // Helpers
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic irq_wr;
  logic ctl_wr;
  // Only these writes may take a pending request away
  assign irq_wr = wr_stb && (addr == IRQ_CLR_ADDR || addr == IRQ_EN_ADDR);
  assign ctl_wr = wr_stb && (addr == CTRL_ADDR);
  sequence pd_held;
    power_down [*4];
  endsequence
  sequence off_held;
    !analog_power [*4];
  endsequence
  // ====================
  // Assertions
  a_req_gate: assert property (conv_irq_req |-> conv_irq_en)
    else $error("request without enable");
  a_req_sticky: assert property (conv_irq_req && !ctl_wr ##1 conv_irq_en |-> conv_irq_req)
    else $error("request dropped by itself");
  a_irq_sticky: assert property (irq && !irq_wr |=> irq)
    else $error("interrupt dropped by itself");
  a_one_channel: assert property ($onehot0(channel_connect))
    else $error("more than one input connected");
  a_channel_match: assert property (channel_connect != 8'h00 |->
    channel_connect == (8'h01 << input_select))
    else $error("connected input differs from select");
  a_connect_sampling: assert property (channel_connect != 8'h00 |-> sample_hold)
    else $error("input connected outside sampling");
  a_pd_power: assert property (power_down |=> !analog_power)
    else $error("powered in power-down");
  a_pd_nosample: assert property (pd_held |-> !sample_hold)
    else $error("sampling in power-down");
  a_off_nosample: assert property (off_held |-> !sample_hold)
    else $error("sampling while off");
endmodule : adc_conv_monitor
bind adc_conv_ctrl adc_conv_monitor i_adc_conv_monitor (
  .mclk(mclk), .srst(srst), .addr(addr), .wr_stb(wr_stb), .power_down(power_down),
  .conv_irq_en(conv_irq_en), .conv_irq_req(conv_irq_req), .irq(irq),
  .input_select(input_select), .channel_connect(channel_connect),
  .analog_power(analog_power), .sample_hold(sample_hold)
);
`default_nettype wire

// ===== dv/afe_model.sv
// Behavioural analog front end: input mux, hold capacitor and comparator
`timescale 1ns/1ps
`default_nettype none
module afe_model (
  input  wire logic            mclk,
  input  wire logic            analog_power,
  input  wire logic [7:0]      channel_connect,
  input  wire logic [9:0]      dac_code,
  input  wire logic [7:0][9:0] levels,
  output var  logic            cmp_pin
);
  logic [9:0] held = 10'h000;
  logic       wobble = 1'b0;
  // Hold tracks the connected input; with nothing connected the charge stays
  always_ff @(posedge mclk) begin
    wobble <= ~wobble;
    for (int i = 0; i < 8; i++) begin
      if (channel_connect[i]) begin
        held <= levels[i];
      end
    end
  end
  // Input sits half a step above its code, so a tie reads as above
  // Unpowered comparator output wanders, so a stale value cannot pass
  assign cmp_pin = analog_power ? (held >= dac_code) : wobble;
endmodule : afe_model
`default_nettype wire

// ===== rtl/adc_conv_ctrl.sv
// Converter control: registers, start/stop, compare, flags and analog front-end steering
//
// How it works
// RQ1: Produce a 10-bit SAR result from input.
// RQ2: Connect only one of eight inputs.
// RQ3: Select code 000..111 picks inputs 0..7.
// RQ4: Enable bit switches the converter on, off.
// RQ5: Writing start begins conversion or compare.
// RQ6: Completion stores result and sets the flag.
// RQ7: Conversion mode clears start bit at completion.
// RQ8: Clearing start mid-conversion aborts it.
// RQ9: Compare runs only with compare and enable.
// RQ10: Compare flags only when input exceeds value.
// RQ11: Compare never clears start; runs until cleared.
// RQ12: Hardware sets the flag; software clears.
// RQ13: Request only when flag and enable set.
// RQ14: Runs in idle; stopped in power-down.
// RQ15: Converter clock is 2..32 system clocks.
// RQ16: Sample is field+1 clamped; plus 12 clocks.
// RQ17: Start ignored while the converter is off.
//
// Register map
// 0x93 control: on, flag, compare, spare, select, start
// 0x94 timing: divider, spare, sample length
// 0xa0/0xa1 result, bits 9..2 then 1..0
// 0xa2/0xa3 compare value, same split
// 0xa4 status, 0xa5 clear, 0xa6 enable
// Flag bit: write zero to clear it
// Unmapped reads give zero
//
// Timing
// A start runs from the next edge; after
// sample + 12 converter clocks, result,
// flag and status follow one clock later.
// Status and flag stay set until cleared.
//
// Limits
// Comparator pin passes four flops, so a
// trial lags its code by about six clocks;
// the two fastest divider codes are too short
// for valid codes and serve timing only.
// Power-down keeps the start bit set, so
// the conversion restarts afterwards.
// Compare mode refreshes the result and
// status bit zero on every pass.
// A new select reaches the input switches one clock after the write, even mid-sample.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl
  import adc_ctrl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,

  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output var  logic [7:0] rdata,

  // System side
  input  wire logic       power_down,
  input  wire logic       conv_irq_en,
  output var  logic       conv_irq_req,
  output var  logic       irq,

  // Analog front end
  input  wire logic       cmp_pin,
  output var  logic [2:0] input_select,
  output var  logic [7:0] channel_connect,
  output var  logic       analog_power,
  output var  logic       sample_hold,
  output var  logic [9:0] dac_code
);

  // ==========================================================================
  // State
  // Software-visible registers
  control_s   ctrl_reg;
  timing_s    time_reg;
  logic [9:0] result_reg;
  logic [9:0] cmpv_reg;
  logic [1:0] stat_reg;
  logic [1:0] irq_en_reg;

  // Comparator synchroniser stages and the agreed level
  logic       cmp_s1_reg;
  logic       cmp_s2_reg;
  logic       cmp_s3_reg;
  logic       cmp_stable_reg;

  // Sequencer links and decoded events
  logic       run;
  logic       tick;
  logic       sampling;
  logic [9:0] sar_code;
  logic [9:0] sar_result;
  logic       sar_done;
  logic       hit;
  logic       flag_set;
  logic       ctrl_wr;
  logic [1:0] stat_set;

  // ==========================================================================
  // Run gating: the enable bit, the start bit and power-down together
  // Dropping run holds the sequencer in reset, which is also the abort path
  assign run      = ctrl_reg.go && ctrl_reg.on && !power_down;  // RQ4 RQ9 RQ14
  assign ctrl_wr  = wr_stb && (addr == CTRL_ADDR);
  // Compare sees the fresh result in the cycle done is high
  assign hit      = sar_result > cmpv_reg;  // RQ10
  // In compare mode a completion flags only on a hit
  assign flag_set = sar_done && (!ctrl_reg.cmp_en || hit);  // RQ6 RQ10 RQ12
  // Status bit zero marks every pass, bit one a compare hit
  assign stat_set = {sar_done && ctrl_reg.cmp_en && hit, sar_done};

  // ==========================================================================
  // Comparator pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmp_s1_reg     <= 1'b0;
      cmp_s2_reg     <= 1'b0;
      cmp_s3_reg     <= 1'b0;
      cmp_stable_reg <= 1'b0;
    end else begin
      // Only stage two reads stage one, which may be metastable
      cmp_s1_reg <= cmp_pin;
      cmp_s2_reg <= cmp_s1_reg;
      cmp_s3_reg <= cmp_s2_reg;
      // A one-cycle glitch never reaches the agreed level
      if (cmp_s2_reg == cmp_s3_reg) begin
        cmp_stable_reg <= cmp_s3_reg;
      end
    end
  end

  // ==========================================================================
  // Converter clock and SAR sequencer
  // The divider restarts with run, so each start gets full converter clocks
  tad_divider u_div (
    .mclk     (mclk),
    .srst     (srst),
    .enable   (run),
    .div_code (time_reg.div),
    .tick     (tick)
  );

  // Clearing the start bit drops run, which aborts the sequencer
  // A partial code never reaches the result register
  sar_engine u_sar (
    .mclk         (mclk),
    .srst         (srst),
    .run          (run),  // RQ8
    .tick         (tick),
    .sample_field (time_reg.samp),
    .cmp_above    (cmp_stable_reg),
    .sampling     (sampling),
    .dac_code     (sar_code),
    .result       (sar_result),
    .done         (sar_done)
  );

  // ==========================================================================
  // Control register: hardware clear first, software write may override,
  // and a hardware flag set wins over a software clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_reg <= control_s'(CTRL_RESET);
    end else begin
      // Conversion mode ends itself; compare mode keeps running
      if (sar_done && !ctrl_reg.cmp_en) begin
        ctrl_reg.go <= 1'b0;  // RQ7 RQ11
      end

      // Switching the module off also drops a pending start
      if (!ctrl_reg.on) begin
        ctrl_reg.go <= 1'b0;  // RQ4
      end

      // Flag: writing zero clears it, writing one keeps it
      if (ctrl_wr) begin
        ctrl_reg.on     <= wdata[7];  // RQ4
        ctrl_reg.flag   <= ctrl_reg.flag & wdata[6];  // RQ12
        ctrl_reg.cmp_en <= wdata[5];  // RQ9
        ctrl_reg.unused <= 1'b0;
        ctrl_reg.sel    <= wdata[3:1];  // RQ3
        ctrl_reg.go     <= wdata[0] & wdata[7];  // RQ5 RQ8 RQ17
      end

      // Last, so a hardware set beats a software clear
      if (flag_set) begin
        ctrl_reg.flag <= 1'b1;  // RQ6 RQ12
      end
    end
  end

  // ==========================================================================
  // Timing register and compare value
  // Spare bits are stored as zero so they read back as zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      time_reg <= timing_s'(TIME_RESET);
    end else if (wr_stb && addr == TIME_ADDR) begin
      time_reg <= timing_s'({wdata[7:5], 1'b0, wdata[3:0]});  // RQ15 RQ16
    end
  end

  // High byte holds bits 9..2, low byte holds bits 1..0
  // Halves land on their own; compare may see a mix between the two writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmpv_reg <= CMPV_RESET;
    end else if (wr_stb && addr == CMPV_HI_ADDR) begin
      cmpv_reg[9:2] <= wdata;
    end else if (wr_stb && addr == CMPV_LO_ADDR) begin
      cmpv_reg[1:0] <= wdata[1:0];
    end
  end

  // ==========================================================================
  // Result register: updated only on a completed conversion, never on abort
  // Compare mode refreshes it on every pass, hit or not
  always_ff @(posedge mclk) begin
    if (srst) begin
      result_reg <= RESULT_RESET;
    end else if (sar_done) begin
      result_reg <= sar_result;  // RQ6
    end
  end

  // ==========================================================================
  // Interrupt status: sticky, cleared by writing ones, set wins over clear
  // The clear register keeps no state and reads as zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      stat_reg <= IRQ_RESET;
    end else if (wr_stb && addr == IRQ_CLR_ADDR) begin
      stat_reg <= (stat_reg & ~wdata[1:0]) | stat_set;
    end else begin
      stat_reg <= stat_reg | stat_set;
    end
  end

  // Per-bit enables of the status register
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_en_reg <= IRQ_RESET;
    end else if (wr_stb && addr == IRQ_EN_ADDR) begin
      irq_en_reg <= wdata[1:0];
    end
  end

  // irq is logic on flip-flops only, so it carries no glitch; conv_irq_req also passes the conv_irq_en input
  // irq follows the status bits; the request follows the control flag
  assign irq          = |(stat_reg & irq_en_reg);
  assign conv_irq_req = ctrl_reg.flag && conv_irq_en;  // RQ13 RQ14

  // ==========================================================================
  // Read port: data stand in the cycle after the strobe; unmapped reads zero
  // Zero between reads keeps a stale byte off the bus
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      unique case (addr)
        CTRL_ADDR:     rdata <= ctrl_reg;
        TIME_ADDR:     rdata <= time_reg;
        // Ten-bit values split as bits 9..2 and bits 1..0
        RES_HI_ADDR:   rdata <= result_reg[9:2];
        RES_LO_ADDR:   rdata <= {6'h00, result_reg[1:0]};
        CMPV_HI_ADDR:  rdata <= cmpv_reg[9:2];
        CMPV_LO_ADDR:  rdata <= {6'h00, cmpv_reg[1:0]};
        IRQ_STAT_ADDR: rdata <= {6'h00, stat_reg};
        IRQ_EN_ADDR:   rdata <= {6'h00, irq_en_reg};
        default:       rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // Front-end steering: at most one input switch closed, and only while sampling
  // All registered, so the switches never see a decode glitch
  always_ff @(posedge mclk) begin
    if (srst) begin
      input_select    <= 3'h0;
      channel_connect <= 8'h00;
      analog_power    <= 1'b0;
      sample_hold     <= 1'b0;
      dac_code        <= 10'h000;
    end else begin
      input_select    <= ctrl_reg.sel;  // RQ3
      channel_connect <= sampling ? (8'h01 << ctrl_reg.sel) : 8'h00;  // RQ2 RQ3
      analog_power    <= ctrl_reg.on && !power_down;  // RQ4 RQ14
      sample_hold     <= sampling;
      // Trial code leaves one cycle after the sequencer sets it
      dac_code        <= sar_code;
    end
  end

endmodule : adc_conv_ctrl
`default_nettype wire

// ===== rtl/adc_ctrl_pkg.sv
// Package: register map, field layouts, reset values and timing counts of the converter control
package adc_ctrl_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] CTRL_ADDR     = 8'h93;
  localparam logic [7:0] TIME_ADDR     = 8'h94;
  localparam logic [7:0] RES_HI_ADDR   = 8'ha0;
  localparam logic [7:0] RES_LO_ADDR   = 8'ha1;
  localparam logic [7:0] CMPV_HI_ADDR  = 8'ha2;
  localparam logic [7:0] CMPV_LO_ADDR  = 8'ha3;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'ha4;
  localparam logic [7:0] IRQ_CLR_ADDR  = 8'ha5;
  localparam logic [7:0] IRQ_EN_ADDR   = 8'ha6;

  // ==========================================================================
  // Reset values and field positions
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] TIME_RESET    = 8'h00;
  localparam logic [9:0] RESULT_RESET  = 10'h000;
  localparam logic [9:0] CMPV_RESET    = 10'h000;
  localparam logic [1:0] IRQ_RESET     = 2'h0;
  localparam int         STAT_DONE_BIT = 0;
  localparam int         STAT_HIT_BIT  = 1;

  // ==========================================================================
  // Conversion timing in converter clocks
  localparam logic [3:0] SAMPLE_MIN    = 4'h2;
  localparam logic [3:0] SAMPLE_MAX    = 4'hf;
  localparam logic [3:0] CONV_LAST     = 4'hb;   // Steps 0..11 make 12 converter clocks
  localparam logic [9:0] SAR_MSB_CODE  = 10'h200;

  // ==========================================================================
  // Register layouts
  typedef struct packed {
    logic       on;
    logic       flag;
    logic       cmp_en;
    logic       unused;
    logic [2:0] sel;
    logic       go;
  } control_s;

  typedef struct packed {
    logic [2:0] div;
    logic       unused;
    logic [3:0] samp;
  } timing_s;

  // Converter clock period in system clocks, in code order
  function automatic logic [5:0] tad_sys_cycles(input logic [2:0] code);
    logic [5:0] n;
    n = 6'h02;
    unique case (code)
      3'h0: n = 6'h02;
      3'h1: n = 6'h04;
      3'h2: n = 6'h06;
      3'h3: n = 6'h08;
      3'h4: n = 6'h0c;
      3'h5: n = 6'h10;
      3'h6: n = 6'h18;
      3'h7: n = 6'h20;
    endcase
    return n;
  endfunction : tad_sys_cycles

  // Sample length is field plus one, held between the two limits
  function automatic logic [3:0] sample_tads(input logic [3:0] field);
    logic [4:0] v;
    v = {1'b0, field} + 5'h01;
    if (v < {1'b0, SAMPLE_MIN}) begin
      v = {1'b0, SAMPLE_MIN};
    end
    if (v > {1'b0, SAMPLE_MAX}) begin
      v = {1'b0, SAMPLE_MAX};
    end
    return v[3:0];
  endfunction : sample_tads

endpackage : adc_ctrl_pkg

// ===== rtl/sar_engine.sv
// Successive-approximation sequencer: sample phase, then twelve converter clocks of bit trials
`timescale 1ns/1ps
`default_nettype none
module sar_engine
  import adc_ctrl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [3:0] sample_field,
  input  wire logic       cmp_above,
  output var  logic       sampling,
  output var  logic [9:0] dac_code,
  output var  logic [9:0] result,
  output var  logic       done
);

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sar_state_e;

  sar_state_e state_reg;
  logic [3:0] step_reg;
  logic [3:0] bit_idx;

  assign bit_idx = 4'(10) - step_reg;

  // ==========================================================================
  // Dropping run aborts at once; the partial code is never published
  always_ff @(posedge mclk) begin
    if (srst || !run) begin
      state_reg <= ST_IDLE;
      step_reg  <= 4'h0;
      sampling  <= 1'b0;
      dac_code  <= 10'h000;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_SAMPLE;
          step_reg  <= 4'h0;
          sampling  <= 1'b1;
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (step_reg + 4'h1 >= sample_tads(sample_field)) begin  // RQ16
              state_reg <= ST_CONVERT;
              step_reg  <= 4'h0;
              sampling  <= 1'b0;
            end else begin
              step_reg <= step_reg + 4'h1;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            if (step_reg == 4'h0) begin
              dac_code <= SAR_MSB_CODE;
            end else if (step_reg <= 4'ha) begin
              // Keep the trial bit when the input sits above the trial level
              dac_code[bit_idx] <= cmp_above;  // RQ1
              if (bit_idx != 4'h0) begin
                dac_code[bit_idx - 4'h1] <= 1'b1;
              end
            end
            if (step_reg == CONV_LAST) begin
              state_reg <= ST_SAMPLE;  // RQ16
              step_reg  <= 4'h0;
              sampling  <= 1'b1;
              done      <= 1'b1;
            end else begin
              step_reg <= step_reg + 4'h1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Finished code is held until the next completion
  always_ff @(posedge mclk) begin
    if (srst) begin
      result <= RESULT_RESET;
    end else if (run && tick && state_reg == ST_CONVERT && step_reg == CONV_LAST) begin
      result <= dac_code;  // RQ1
    end
  end

endmodule : sar_engine
`default_nettype wire

// ===== rtl/tad_divider.sv
// Converter clock divider: one-cycle tick every selected number of system clocks
`timescale 1ns/1ps
`default_nettype none
module tad_divider
  import adc_ctrl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       enable,
  input  wire logic [2:0] div_code,
  output var  logic       tick
);

  logic [5:0] count_reg;
  logic [5:0] last;

  assign last = tad_sys_cycles(div_code) - 6'h01;  // RQ15

  // ==========================================================================
  // Count restarts whenever the converter is not running, so ticks align to the start
  always_ff @(posedge mclk) begin
    if (srst || !enable) begin
      count_reg <= 6'h00;
      tick      <= 1'b0;
    end else if (count_reg >= last) begin
      count_reg <= 6'h00;
      tick      <= 1'b1;  // RQ15
    end else begin
      count_reg <= count_reg + 6'h01;
      tick      <= 1'b0;
    end
  end

endmodule : tad_divider
`default_nettype wire
